/* File: bench/test_wrx_seq.sv */
// Self-checking bench of the receiver sequencer
`timescale 1ns/10ps
module test_wrx_seq;
    import wrx_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, mode_pma = 1'b0, adapter_present = 1'b0;
    logic temp_hot = 1'b0, ctrl_high = 1'b0, ctrl_low = 1'b0, internal_fault = 1'b0;
    logic rect_ovp = 1'b0, input_surge = 1'b0, ping_memory_node = 1'b0;
    logic comm_limit_control_pin = 1'b0;
    logic [15:0] vrect_mv = 16'h1b58;
    logic [10:0] iout_ma = 11'h000, imax_ma = 11'h3e8;
    logic [3:0] lag = 4'h1;
    logic pkt_done, pkt_req, vout_en, comm_limit_active;
    logic pad_detect_output, pad_detect_output_oe_n;
    wrx_pkt_e pkt_kind, last_kind, k;
    logic [7:0] pkt_data, last_data, d;
    logic [15:0] rect_target_mv;
    logic [11:0] comm_limit_ma;
    int pkt_cnt, fail_count = 0, cmp_count = 0, i, n, c0;
    int lim_i[8] = '{50, 99, 100, 250, 399, 400, 700, 1000};
    logic [7:0] ept_code[5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h03};

    wrx_seq #(.CEP_FAST_CYC(20), .CEP_SLOW_CYC(60)) u_wrx_seq (
        .sys_clk, .rst_n, .mode_pma, .adapter_present, .temp_hot, .ctrl_high, .ctrl_low,
        .internal_fault, .rect_ovp, .input_surge, .ping_memory_node,
        .comm_limit_control_pin, .vrect_mv, .iout_ma, .imax_ma, .pkt_done, .pkt_req,
        .pkt_kind, .pkt_data, .vout_en, .rect_target_mv, .comm_limit_active,
        .comm_limit_ma, .pad_detect_output, .pad_detect_output_oe_n
    );
    wrx_tx_model u_wrx_tx_model (
        .sys_clk, .rst_n, .pkt_req, .pkt_kind, .pkt_data, .pkt_done, .lag, .last_kind,
        .last_data, .pkt_cnt
    );

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic step(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic pkt();
        int j;
        c0 = pkt_cnt;
        for (j = 0; j < 400 && pkt_cnt == c0; j++) step(1);
        if (pkt_cnt == c0) chk(16'hffff, 16'h0000);
        k = last_kind;
        d = last_data;
    endtask

    task automatic boot(input logic pma, input logic ad);
        rst_n = 1'b0;
        {adapter_present, ctrl_high, internal_fault, temp_hot, ctrl_low} = 5'h00;
        {rect_ovp, input_surge, ping_memory_node} = 3'h0;
        mode_pma = pma;
        adapter_present = ad;
        vrect_mv = 16'h1b58;
        step(6);
        rst_n = 1'b1;
        for (i = 0; i < 3 && !ad; i++) begin
            pkt();
            if (!pma) chk(k, 16'(i));
        end
    endtask

    task automatic to_act(input logic pma);
        boot(pma, 1'b0);
        chk(vout_en, 1'b0);
        pkt();
        if (!pma) chk(d, 8'h2e);
        chk(vout_en, 1'b0);
        vrect_mv = 16'h2328;
        for (i = 0; i < 200 && vout_en !== 1'b1; i++) step(1);
        chk(vout_en, 1'b1);
    endtask

    task automatic wait_req();
        int j;
        for (j = 0; j < 100 && pkt_req !== 1'b0; j++) step(1);
        for (j = 0; j < 400 && pkt_req !== 1'b1; j++) step(1);
    endtask

    function automatic logic [15:0] exp_tgt(input int c);
        if (c * 4 < 1000) return 16'h1b58;
        if (c * 4 < 3000) return 16'h1c84;
        return 16'h1db0;
    endfunction

    function automatic logic [7:0] exp_cep(input int t, input int v);
        int e;
        e = (t - v) >>> 5;
        if (e > 127) e = 127;
        if (e < -127) e = -127;
        return 8'(e);
    endfunction

    initial begin
        #200000;
        fail_count++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'h0d67));
        to_act(1'b0);
        for (n = 0; n < 6; n++) begin
            iout_ma = 11'($urandom % 1000);
            vrect_mv = 16'h1770 + 16'($urandom % 3000);
            step(4);
            chk(rect_target_mv, exp_tgt(iout_ma));
            pkt();
            pkt();
            chk(d, exp_cep(exp_tgt(iout_ma), vrect_mv));
        end
        $display("Test target tracking done");
        lag = 4'h8;
        for (n = 0; n < 9; n++) begin
            comm_limit_control_pin = (n == 8);
            iout_ma = 11'(lim_i[n % 8]);
            wait_req();
            step(3);
            chk(comm_limit_active, 16'(n < 8 && lim_i[n] >= 100));
            if (n < 8 && lim_i[n] >= 100) begin
                chk(comm_limit_ma, 16'(lim_i[n] < 400 ? lim_i[n] + 50 : lim_i[n] - 50));
            end
        end
        $display("Test comm limit done");
        lag = 4'h0;
        for (n = 0; n < 2; n++) begin
            input_surge = (n == 1);
            step(2);
            c0 = pkt_cnt;
            step(1200);
            chk((pkt_cnt - c0) inside {[(n ? 50 : 17) : (n ? 61 : 21)]}, 1'b1);
        end
        input_surge = 1'b0;
        ping_memory_node = 1'b1;
        step(4);
        chk({pad_detect_output, pad_detect_output_oe_n}, 2'b00);
        ping_memory_node = 1'b0;
        step(4);
        chk(pad_detect_output_oe_n, 1'b1);
        iout_ma = 11'h384;
        rect_ovp = 1'b1;
        step(8);
        chk(vout_en, 1'b0);
        chk(rect_target_mv, 16'h1b58);
        $display("Test surge, pad and overvoltage done");
        for (n = 0; n < 5; n++) begin
            to_act(1'b0);
            {adapter_present, ctrl_high, internal_fault, temp_hot, ctrl_low} = 5'h10 >> n;
            for (i = 0; i < 10 && k !== WRX_PK_EPT; i++) pkt();
            chk(k, WRX_PK_EPT);
            chk(d, ept_code[n]);
            c0 = pkt_cnt;
            step(200);
            chk(pkt_cnt == c0, 1'b1);
        end
        $display("Test end codes done");
        to_act(1'b1);
        vrect_mv = 16'h1770;
        pkt();
        pkt();
        temp_hot = 1'b1;
        ping_memory_node = 1'b1;
        for (i = 0; i < 10 && k === WRX_PK_DEC; i++) pkt();
        chk(k, WRX_PK_INC);
        chk(d, 8'h03);
        chk(pad_detect_output_oe_n, 1'b1);
        $display("Test end of charge done");
        boot(1'b0, 1'b1);
        pkt();
        chk(k, WRX_PK_EPT);
        chk(d, 8'h00);
        $display("Test startup shutdown done");
        boot(1'b0, 1'b0);
        for (n = 0; n < 80; n++) begin
            pkt();
            if (k !== WRX_PK_CEP) break;
        end
        chk(n, 64);
        chk(k, WRX_PK_EPT);
        chk(d, 8'h04);
        chk(vout_en, 1'b0);
        $display("Test startup timeout done");
        wrap_up();
    end
endmodule

/* File: bench/wrx_tx_model.sv */
// Transmitter model that accepts receiver packets after a set lag
`timescale 1ns/10ps
module wrx_tx_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Packet port
    input wire logic pkt_req,
    input wire wrx_pkg::wrx_pkt_e pkt_kind,
    input wire logic [7:0] pkt_data,
    output logic pkt_done,
    // Control and log
    input wire logic [3:0] lag,
    output wrx_pkg::wrx_pkt_e last_kind,
    output logic [7:0] last_data,
    output int pkt_cnt
);
    import wrx_pkg::*;
    initial begin
        pkt_done = 1'b0;
        pkt_cnt = 0;
        last_kind = WRX_PK_SS;
        last_data = 8'h00;
        forever begin
            @(posedge sys_clk);
            #1;
            if (rst_n && pkt_req) begin
                repeat (lag) @(posedge sys_clk);
                #1;
                if (pkt_req) begin
                    pkt_done = 1'b1;
                    last_kind = pkt_kind;
                    last_data = pkt_data;
                    @(posedge sys_clk);
                    #1;
                    pkt_done = 1'b0;
                    pkt_cnt = pkt_cnt + 1;
                end
            end
        end
    end
endmodule

/* File: core/wrx_pkt_timer.sv */
// Packet interval timer with restart
`timescale 1ns/10ps
module wrx_pkt_timer (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control
    input wire logic restart,
    input wire wrx_pkg::wrx_cnt_t period,
    // Event
    output logic tick
);
    import wrx_pkg::*;

    wrx_cnt_t cnt_ff;
    wrx_cnt_t nxt_cnt;
    logic tick_ff;
    logic nxt_tick;

    always_comb begin
        nxt_cnt = cnt_ff + 27'h1;
        nxt_tick = 1'b0;
        if (restart) begin
            nxt_cnt = 27'h0;
        end else if (cnt_ff >= period - 27'h1) begin
            nxt_cnt = 27'h0;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 27'h0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;
endmodule

/* File: core/wrx_seq.sv */
// Startup, power control and end of transfer sequencer of the receiver
// Functional notes
// - WPC: first three packets are signal strength, configuration, identification.
// - Shutdown condition at startup ends transfer instead of signal strength.
// - WPC: power control starts only after all three startup packets accepted; PMA starts it at once.
// - Request rectifier above 8 V before enabling output supply.
// - Active: rectifier target from current fraction, tracked by control errors.
// - Active: end conditions checked whenever no packet is pending, any one ends transfer.
// - Input surge, startup ramp or overvoltage: errors every 30 ms, otherwise every 250 ms.
// - Rectifier overvoltage: output off, steer back to regulation target.
// - Hot: over-temperature end in WPC, end of charge in PMA.
// - WPC: pad detect driven low while ping memory above 1.6 V.
// - WPC: limit pin high disables communication limit; low or floating enables.
// - Comm limit: none below 100 mA, +50 mA to 400 mA, else -50 mA.
// - End codes: unknown 0, charge done 1, fault 2, temp 3, volt 4.
// - Control pin high sends charge complete or end of charge.
// - WPC: startup target missed after 64 errors sends over-voltage end.
`timescale 1ns/10ps
`include "wrx_defs.svh"
module wrx_seq #(
    parameter int unsigned CEP_FAST_CYC = `WRX_CEP_FAST_MS * `WRX_CYC_PER_MS,
    parameter int unsigned CEP_SLOW_CYC = `WRX_CEP_SLOW_MS * `WRX_CYC_PER_MS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Comparator and pin levels, asynchronous
    input wire logic mode_pma,
    input wire logic adapter_present,
    input wire logic temp_hot,
    input wire logic ctrl_high,
    input wire logic ctrl_low,
    input wire logic internal_fault,
    input wire logic rect_ovp,
    input wire logic input_surge,
    input wire logic ping_memory_node,
    input wire logic comm_limit_control_pin,
    // Measurements, same clock
    input wire logic [15:0] vrect_mv,
    input wire logic [10:0] iout_ma,
    input wire logic [10:0] imax_ma,
    // Packet modulator
    input wire logic pkt_done,
    output logic pkt_req,
    output wrx_pkg::wrx_pkt_e pkt_kind,
    output logic [7:0] pkt_data,
    // Power path
    output logic vout_en,
    output logic [15:0] rect_target_mv,
    output logic comm_limit_active,
    output logic [11:0] comm_limit_ma,
    // Pad detect, open drain
    output logic pad_detect_output,
    output logic pad_detect_output_oe_n
);
    import wrx_pkg::*;

    // Shutdown reason: bit 8 set when any condition holds
    function automatic logic [8:0] shut_reason(input logic [`WRX_SY_W-1:0] s);
        if (s[`WRX_SY_AD]) begin
            shut_reason = {1'b1, `WRX_EPT_UNKNOWN};
        end else if (s[`WRX_SY_CTRL_HI]) begin
            shut_reason = {1'b1, `WRX_EPT_CHARGE_DONE};
        end else if (s[`WRX_SY_FAULT]) begin
            shut_reason = {1'b1, `WRX_EPT_FAULT};
        end else if (s[`WRX_SY_HOT] || s[`WRX_SY_CTRL_LO]) begin
            shut_reason = {1'b1, `WRX_EPT_OVER_TEMP};
        end else begin
            shut_reason = {1'b0, `WRX_EPT_UNKNOWN};
        end
    endfunction

    // Control error value, positive asks for more power
    function automatic logic [7:0] cep_val(input logic [15:0] tgt, input logic [15:0] v);
        logic signed [16:0] diff;
        diff = $signed({1'b0, tgt}) - $signed({1'b0, v});
        diff = diff >>> 5;
        if (diff > 17'sd127) begin
            cep_val = 8'h7f;
        end else if (diff < -17'sd127) begin
            cep_val = 8'h81;
        end else begin
            cep_val = diff[7:0];
        end
    endfunction

    // Rectifier target from output current as a fraction of maximum
    function automatic logic [15:0] tgt_of(input logic [10:0] i, input logic [10:0] imax);
        if ({2'b00, i} < {2'b00, imax} / 13'h4) begin
            tgt_of = `WRX_TGT_LOW_MV;
        end else if ({2'b00, i} < ({2'b00, imax} * 13'h3) / 13'h4) begin
            tgt_of = `WRX_TGT_MID_MV;
        end else begin
            tgt_of = `WRX_TGT_HIGH_MV;
        end
    endfunction

    // Input synchroniser
    logic [`WRX_SY_W-1:0] sync1_ff;
    logic [`WRX_SY_W-1:0] sync2_ff;
    logic [`WRX_SY_W-1:0] raw_in;
    // Marks when both stages hold sampled pins, so startup decisions see real levels
    logic [1:0] warm_ff;

    assign raw_in = {comm_limit_control_pin, ping_memory_node, input_surge, rect_ovp,
                     internal_fault, ctrl_low, ctrl_high, temp_hot, adapter_present, mode_pma};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            warm_ff <= 2'b00;
        end else begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
            warm_ff <= {warm_ff[0], 1'b1};
        end
    end

    logic pma;
    logic ovp;
    logic [8:0] shut;

    assign pma = sync2_ff[`WRX_SY_PMA];
    assign ovp = sync2_ff[`WRX_SY_OVP];
    assign shut = shut_reason(sync2_ff);

    // Sequencer state
    wrx_state_e state_ff;
    wrx_state_e nxt_state;
    logic pkt_req_ff;
    logic nxt_req;
    wrx_pkt_e pkt_kind_ff;
    wrx_pkt_e nxt_kind;
    logic [7:0] pkt_data_ff;
    logic [7:0] nxt_data;
    logic vout_en_ff;
    logic nxt_vout;
    logic [15:0] tgt_ff;
    logic [15:0] nxt_tgt;
    logic [6:0] cep_cnt_ff;
    logic [6:0] nxt_cnt;
    logic cep_due_ff;
    logic nxt_due;
    logic issue_cep;
    logic tick;
    logic fast;
    logic [7:0] cep;
    wrx_cnt_t period;

    assign fast = (state_ff == WRX_ST_RAMP) || sync2_ff[`WRX_SY_SURGE] || ovp;
    assign period = fast ? wrx_cnt_t'(CEP_FAST_CYC) : wrx_cnt_t'(CEP_SLOW_CYC);
    assign cep = cep_val(tgt_ff, vrect_mv);

    wrx_pkt_timer u_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .restart(state_ff != nxt_state),
        .period(period),
        .tick(tick)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_req = pkt_req_ff;
        nxt_kind = pkt_kind_ff;
        nxt_data = pkt_data_ff;
        nxt_vout = vout_en_ff;
        nxt_tgt = tgt_ff;
        nxt_cnt = cep_cnt_ff;
        issue_cep = 1'b0;
        if (pkt_req_ff && pkt_done) begin
            nxt_req = 1'b0;
        end
        case (state_ff)
            WRX_ST_IDLE: begin
                if (!warm_ff[1]) begin
                    nxt_state = WRX_ST_IDLE;
                end else if (shut[8]) begin
                    nxt_state = WRX_ST_EPT;
                    nxt_data = shut[7:0];
                end else if (pma) begin
                    nxt_state = WRX_ST_RAMP;
                end else begin
                    nxt_state = WRX_ST_SS;
                end
            end
            WRX_ST_SS, WRX_ST_CFG, WRX_ST_ID: begin
                if (!pkt_req_ff) begin
                    nxt_req = 1'b1;
                    if (state_ff == WRX_ST_SS) begin
                        nxt_kind = WRX_PK_SS;
                        nxt_data = vrect_mv[15:8];
                    end else if (state_ff == WRX_ST_CFG) begin
                        nxt_kind = WRX_PK_CFG;
                        nxt_data = `WRX_CFG_BYTE;
                    end else begin
                        nxt_kind = WRX_PK_ID;
                        nxt_data = `WRX_ID_BYTE;
                    end
                end else if (pkt_done) begin
                    if (state_ff == WRX_ST_SS) begin
                        nxt_state = WRX_ST_CFG;
                    end else if (state_ff == WRX_ST_CFG) begin
                        nxt_state = WRX_ST_ID;
                    end else begin
                        nxt_state = WRX_ST_RAMP;
                    end
                end
            end
            WRX_ST_RAMP: begin
                nxt_tgt = `WRX_RAMP_TGT_MV;
                if (pkt_req_ff) begin
                    if (pkt_done && pkt_kind_ff == WRX_PK_CEP) begin
                        nxt_cnt = cep_cnt_ff + 7'h1;
                    end
                end else if (shut[8]) begin
                    nxt_state = WRX_ST_EPT;
                    nxt_data = shut[7:0];
                end else if (vrect_mv > `WRX_STARTUP_MV) begin
                    nxt_state = WRX_ST_ACT;
                    nxt_vout = !ovp;
                end else if (cep_cnt_ff == `WRX_RAMP_MAX_CEP) begin
                    nxt_state = WRX_ST_EPT;
                    nxt_data = `WRX_EPT_OVER_VOLT;
                end else if (cep_due_ff) begin
                    issue_cep = 1'b1;
                end
            end
            WRX_ST_ACT: begin
                nxt_tgt = ovp ? `WRX_REG_TGT_MV : tgt_of(iout_ma, imax_ma);
                nxt_vout = !ovp;
                if (!pkt_req_ff && shut[8]) begin
                    nxt_state = WRX_ST_EPT;
                    nxt_data = shut[7:0];
                    nxt_vout = 1'b0;
                end else if (!pkt_req_ff && cep_due_ff) begin
                    issue_cep = 1'b1;
                end
            end
            WRX_ST_EPT: begin
                nxt_vout = 1'b0;
                if (!pkt_req_ff) begin
                    nxt_req = 1'b1;
                    nxt_kind = pma ? WRX_PK_INC : WRX_PK_EPT;
                    nxt_state = WRX_ST_DONE;
                end
            end
            WRX_ST_DONE: begin
                nxt_vout = 1'b0;
            end
            default: begin
                nxt_state = WRX_ST_IDLE;
                nxt_vout = 1'b0;
            end
        endcase
        if (issue_cep) begin
            nxt_req = 1'b1;
            nxt_data = cep;
            if (!pma) begin
                nxt_kind = WRX_PK_CEP;
            end else if (cep[7]) begin
                nxt_kind = WRX_PK_INC;
            end else if (cep == 8'h00) begin
                nxt_kind = WRX_PK_NOCH;
            end else begin
                nxt_kind = WRX_PK_DEC;
            end
        end
        nxt_due = tick || (cep_due_ff && !issue_cep);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= WRX_ST_IDLE;
            pkt_req_ff <= 1'b0;
            pkt_kind_ff <= WRX_PK_SS;
            pkt_data_ff <= 8'h00;
            vout_en_ff <= 1'b0;
            tgt_ff <= 16'h0000;
            cep_cnt_ff <= 7'h00;
            cep_due_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            pkt_req_ff <= nxt_req;
            pkt_kind_ff <= nxt_kind;
            pkt_data_ff <= nxt_data;
            vout_en_ff <= nxt_vout;
            tgt_ff <= nxt_tgt;
            cep_cnt_ff <= nxt_cnt;
            cep_due_ff <= nxt_due;
        end
    end

    // Communication current limit and pad detect
    logic clim_act_ff;
    logic nxt_clim_act;
    logic [11:0] clim_ma_ff;
    logic [11:0] nxt_clim_ma;
    logic pad_oe_n_ff;
    logic nxt_pad_oe_n;

    always_comb begin
        nxt_clim_act = 1'b0;
        nxt_clim_ma = 12'h000;
        if (!pma && !sync2_ff[`WRX_SY_CLIM] && pkt_req_ff && iout_ma >= `WRX_CLIM_LOW_MA) begin
            nxt_clim_act = 1'b1;
            if (iout_ma < `WRX_CLIM_KNEE_MA) begin
                nxt_clim_ma = {1'b0, iout_ma} + `WRX_CLIM_STEP_MA;
            end else begin
                nxt_clim_ma = {1'b0, iout_ma} - `WRX_CLIM_STEP_MA;
            end
        end
        nxt_pad_oe_n = !(!pma && sync2_ff[`WRX_SY_PING_MEMORY_NODE]);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clim_act_ff <= 1'b0;
            clim_ma_ff <= 12'h000;
            pad_oe_n_ff <= 1'b1;
        end else begin
            clim_act_ff <= nxt_clim_act;
            clim_ma_ff <= nxt_clim_ma;
            pad_oe_n_ff <= nxt_pad_oe_n;
        end
    end

    assign pkt_req = pkt_req_ff;
    assign pkt_kind = pkt_kind_ff;
    assign pkt_data = pkt_data_ff;
    assign vout_en = vout_en_ff;
    assign rect_target_mv = tgt_ff;
    assign comm_limit_active = clim_act_ff;
    assign comm_limit_ma = clim_ma_ff;
    assign pad_detect_output = 1'b0;
    assign pad_detect_output_oe_n = pad_oe_n_ff;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_ss_done;
        state_ff == WRX_ST_SS && pkt_req_ff && pkt_done;
    endsequence
    sequence s_cfg_done;
        state_ff == WRX_ST_CFG && pkt_req_ff && pkt_done;
    endsequence

    property p_order;
        s_ss_done |=> state_ff == WRX_ST_CFG ##1 (state_ff == WRX_ST_CFG && pkt_req_ff
            && pkt_kind_ff == WRX_PK_CFG);
    endproperty
    a_order: assert property (p_order) else $error("config must follow signal strength");

    property p_id_after_cfg;
        s_cfg_done |=> state_ff == WRX_ST_ID ##1 pkt_kind_ff == WRX_PK_ID;
    endproperty
    a_id_after_cfg: assert property (p_id_after_cfg) else $error("id must follow config");

    property p_shutdown_start;
        state_ff == WRX_ST_IDLE && shut[8]
            |=> state_ff == WRX_ST_EPT && pkt_data_ff == $past(shut[7:0]);
    endproperty
    a_shutdown_start: assert property (p_shutdown_start) else $error("no startup end");

    property p_vout_gate;
        vout_en_ff |-> state_ff == WRX_ST_ACT && !$past(ovp);
    endproperty
    a_vout_gate: assert property (p_vout_gate) else $error("output enabled too early");

    property p_ramp_exit;
        state_ff == WRX_ST_RAMP && !pkt_req_ff && !shut[8] && vrect_mv > `WRX_STARTUP_MV
            |=> state_ff == WRX_ST_ACT && vout_en_ff == !$past(ovp);
    endproperty
    a_ramp_exit: assert property (p_ramp_exit) else $error("startup target not taken");

    property p_ramp_limit;
        state_ff == WRX_ST_RAMP && !pkt_req_ff && !shut[8] && vrect_mv <= `WRX_STARTUP_MV
            && cep_cnt_ff == `WRX_RAMP_MAX_CEP |=> pkt_data_ff == `WRX_EPT_OVER_VOLT ##1 pkt_req_ff;
    endproperty
    a_ramp_limit: assert property (p_ramp_limit) else $error("over-voltage end missing");

    property p_end_active;
        state_ff == WRX_ST_ACT && !pkt_req_ff && shut[8] |=> state_ff == WRX_ST_EPT && !vout_en_ff
            ##1 pkt_req_ff && state_ff == WRX_ST_DONE;
    endproperty
    a_end_active: assert property (p_end_active) else $error("end of transfer missed");

    property p_ovp_off;
        state_ff == WRX_ST_ACT && ovp |=> !vout_en_ff && tgt_ff == `WRX_REG_TGT_MV;
    endproperty
    a_ovp_off: assert property (p_ovp_off) else $error("overvoltage left output on");

    property p_clim_band;
        !pma && !sync2_ff[`WRX_SY_CLIM] && pkt_req_ff && iout_ma >= `WRX_CLIM_LOW_MA
            && iout_ma < `WRX_CLIM_KNEE_MA |=> clim_ma_ff == {1'b0, $past(iout_ma)} + 12'h032;
    endproperty
    a_clim_band: assert property (p_clim_band) else $error("limit value wrong");

    property p_clim_off;
        sync2_ff[`WRX_SY_CLIM] || iout_ma < `WRX_CLIM_LOW_MA |=> !clim_act_ff;
    endproperty
    a_clim_off: assert property (p_clim_off) else $error("limit active when disabled");

    property p_pad;
        !pma && sync2_ff[`WRX_SY_PING_MEMORY_NODE] |=> !pad_oe_n_ff;
    endproperty
    a_pad: assert property (p_pad) else $error("pad detect not driven");
endmodule

/* File: pkg/wrx_defs.svh */
// Constants of the wireless receiver sequencer
`ifndef WRX_DEFS_SVH
`define WRX_DEFS_SVH

// Clock rate and packet timing
`define WRX_CLK_MHZ 250
`define WRX_CYC_PER_MS (`WRX_CLK_MHZ * 1000)
`define WRX_CEP_FAST_MS 30
`define WRX_CEP_SLOW_MS 250

// Synchronised input positions
`define WRX_SY_PMA 0
`define WRX_SY_AD 1
`define WRX_SY_HOT 2
`define WRX_SY_CTRL_HI 3
`define WRX_SY_CTRL_LO 4
`define WRX_SY_FAULT 5
`define WRX_SY_OVP 6
`define WRX_SY_SURGE 7
`define WRX_SY_PING_MEMORY_NODE 8
`define WRX_SY_CLIM 9
`define WRX_SY_W 10

// End power transfer reason codes
`define WRX_EPT_UNKNOWN 8'h00
`define WRX_EPT_CHARGE_DONE 8'h01
`define WRX_EPT_FAULT 8'h02
`define WRX_EPT_OVER_TEMP 8'h03
`define WRX_EPT_OVER_VOLT 8'h04

// Rectifier voltages in mV and startup error limit
`define WRX_STARTUP_MV 16'h1f40
`define WRX_RAMP_TGT_MV 16'h2134
`define WRX_REG_TGT_MV 16'h1b58
`define WRX_TGT_LOW_MV 16'h1b58
`define WRX_TGT_MID_MV 16'h1c84
`define WRX_TGT_HIGH_MV 16'h1db0
`define WRX_RAMP_MAX_CEP 7'h40

// Communication current limit in mA
`define WRX_CLIM_LOW_MA 11'h064
`define WRX_CLIM_KNEE_MA 11'h190
`define WRX_CLIM_STEP_MA 12'h032

// Startup packet payloads, values arbitrary
`define WRX_CFG_BYTE 8'h05
`define WRX_ID_BYTE 8'h5a

`endif

/* File: pkg/wrx_pkg.sv */
// Types of the wireless receiver sequencer
package wrx_pkg;

    typedef enum logic [2:0] {
        WRX_ST_IDLE = 3'h0,
        WRX_ST_SS = 3'h1,
        WRX_ST_CFG = 3'h3,
        WRX_ST_ID = 3'h2,
        WRX_ST_RAMP = 3'h6,
        WRX_ST_ACT = 3'h7,
        WRX_ST_EPT = 3'h5,
        WRX_ST_DONE = 3'h4
    } wrx_state_e;

    typedef enum logic [2:0] {
        WRX_PK_SS = 3'h0,
        WRX_PK_CFG = 3'h1,
        WRX_PK_ID = 3'h2,
        WRX_PK_CEP = 3'h3,
        WRX_PK_EPT = 3'h4,
        WRX_PK_INC = 3'h5,
        WRX_PK_DEC = 3'h6,
        WRX_PK_NOCH = 3'h7
    } wrx_pkt_e;

    typedef logic [26:0] wrx_cnt_t;

endpackage
